// >>> hdl/ihp_host_port.sv
`timescale 1ns/100ps
// How it works
// R1 - Strobes ignored while chip select high.
// R2 - Select 0: setup write, flags read.
// R3 - Setup write-only, flags read-only, rest both.
// R4 - Host sends three window transfers per access.
// R5 - Bytes counted: control, data, index.
// R6 - Target bits: 00 read, one-set write, 11 register.
// R7 - Register access: op low bit picks read.
// R8 - Index FE device setup, FF frame shift.
// R9 - Store write: control low bits form 9:8.
// R10 - Host checks both busy flags first.
// R11 - Pending on first transfer, cleared within 900ns.
// R12 - Host idles strobes between transfers.
// R13 - Direct accesses disturb the sequence only through the abort bit.
// R14 - Abort bit cancels indirect access.
// R15 - Host names target before reading back.
// R16 - Naming read fetches into data byte.
// R17 - Read-out returns three bytes, pending set.
// R18 - After third read, reset within 900ns.
// R19 - Store holds 256 words of 10 bits.
// R20 - Register read-back shows op bits as one.
// R21 - Unused control bits read back as one.
// R22 - Abort returns sequencer to idle.
// R23 - Strobes synchronised, one transfer per pulse.
module ihp_host_port
   import ihp_pkg::*;
#(
   parameter int DEPTH = ihp_pkg::STORE_DEPTH, // Connection store words.
   parameter int WIDTH = ihp_pkg::STORE_WIDTH  // Connection store word width.
) (
   input wire logic CLOCK_I,               // Device clock, 125 MHz.
   input wire logic RST_B_I,               // Asynchronous reset, active low.
   input wire logic CHIP_SELECT_B_I,       // Chip select, active low.
   input wire logic WRITE_STROBE_B_I,      // Write strobe, active low.
   input wire logic READ_STROBE_B_I,       // Read strobe, active low.
   input wire logic REGISTER_SELECT_I,     // Direct or window select.
   input wire logic [7:0] HOST_DATA_BUS_I, // Data bus from host.
   input wire logic MEMORY_CLEAR_BUSY_I,   // Store clear in progress.
   output logic [7:0] HOST_DATA_BUS_O,     // Data bus to host.
   output logic HOST_DATA_BUS_OE_O,        // Drive enable for the bus.
   output logic [7:0] OPERATING_SETUP_O,   // Operating setup contents.
   output logic [7:0] DEVICE_SETUP_O,      // Device setup contents.
   output logic [7:0] FRAME_SHIFT_SETUP_O  // Frame shift setup contents.
);
   logic [WIDTH-1:0] store [DEPTH];
   logic [11:0] pin_level;
   logic sel_s;
   logic [7:0] data_s;
   logic cs_b;
   logic wr_b;
   logic rd_b;
   logic wr_b_d;
   logic rd_b_d;
   logic sel_d;
   logic [7:0] data_d;
   logic wr_done;
   logic rd_done;
   logic rd_active;
   ihp_seq_t seq;
   ihp_seq_t next_seq;
   logic [7:0] ctl;
   logic [7:0] next_ctl;
   logic [7:0] dat;
   logic [7:0] next_dat;
   logic [7:0] idx;
   logic [7:0] next_idx;
   logic [7:0] ops;
   logic [7:0] next_ops;
   logic [7:0] dev;
   logic [7:0] next_dev;
   logic [7:0] fsh;
   logic [7:0] next_fsh;
   logic pending;
   logic next_pending;
   logic [9:0] timer;
   logic [9:0] next_timer;
   logic store_we;
   logic [7:0] rd_data;
   logic [7:0] next_rd_data;
   logic [7:0] bus_o;
   logic bus_oe;
   logic next_bus_oe;
   logic [7:0] busy_flags;

   // Shapes the logic cannot serve are refused at elaboration.
   if (DEPTH != 256 || WIDTH != 10) begin : g_bad_store
      $error("ihp_host_port store must be 256 x 10.");
   end
   if (ACCESS_LOAD < 1 || ACCESS_LOAD >= 1024) begin : g_bad_timer
      $error("ihp_host_port access timer out of range.");
   end

   // Control byte as it reads back, with unused bits forced high.
   function automatic logic [7:0] ctl_view(input logic [7:0] c);
      ctl_view = c | CTL_UNUSED_MASK; // R21
   endfunction : ctl_view

   //////////////////////////////////////////////////////////////////////////
   // Strobes, select and data cross from the host pins through one synchroniser,
   // so all of them arrive with the same latency.
   ihp_sync #(
      .WIDTH(12)
   ) u_sync (
      .clock_i(CLOCK_I),
      .rst_b_i(RST_B_I),
      .async_i({CHIP_SELECT_B_I, WRITE_STROBE_B_I, READ_STROBE_B_I, REGISTER_SELECT_I,
         HOST_DATA_BUS_I}),
      .level_o(pin_level)
   );

   assign cs_b = pin_level[11];
   assign wr_b = pin_level[10];
   assign rd_b = pin_level[9];
   assign sel_s = pin_level[8];
   assign data_s = pin_level[7:0];

   // A transfer completes on the rising edge of a strobe while selected; address
   // and data are captured while the strobe is low, so they are settled by then.
   assign wr_done = !wr_b_d && wr_b; // R23
   assign rd_done = !rd_b_d && rd_b; // R23
   assign rd_active = !cs_b && !rd_b; // R1

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         wr_b_d <= 1'b1;
         rd_b_d <= 1'b1;
         sel_d <= 1'b0;
         data_d <= 8'h00;
      end else begin
         // Only strobes seen under chip select count.
         wr_b_d <= wr_b | cs_b; // R1
         rd_b_d <= rd_b | cs_b; // R1
         sel_d <= (!wr_b || !rd_b) ? sel_s : sel_d;
         data_d <= !wr_b ? data_s : data_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Indirect sequencer and register file next values.
   always_comb begin
      next_seq = seq;
      next_ctl = ctl;
      next_dat = dat;
      next_idx = idx;
      next_ops = ops;
      next_dev = dev;
      next_fsh = fsh;
      next_pending = pending;
      next_timer = timer;
      store_we = 1'b0;
      if (wr_done && sel_d == REG_SEL_DIRECT) begin
         next_ops = data_d; // R2 R3 R13
      end
      if (wr_done && sel_d == REG_SEL_WINDOW) begin
         case (seq)
            IHP_IDLE: begin
               next_ctl = data_d; // R5
               next_pending = 1'b1; // R11
               next_seq = IHP_GOT_CTL;
            end
            IHP_GOT_CTL: begin
               next_dat = data_d; // R5
               next_seq = IHP_GOT_DATA;
            end
            IHP_GOT_DATA: begin
               next_idx = data_d; // R5
               // Loaded short by the strobe latency so the pins see 900 ns at most.
               next_timer = 10'(ACCESS_LOAD); // R11
               next_seq = IHP_ACCESS;
            end
            default: begin
            end
         endcase
      end
      if (rd_done && sel_d == REG_SEL_WINDOW) begin
         case (seq)
            IHP_IDLE: begin
               next_pending = 1'b1; // R17
               next_seq = IHP_RD_ONE;
            end
            IHP_RD_ONE: begin
               next_seq = IHP_RD_TWO;
            end
            IHP_RD_TWO: begin
               next_timer = 10'(ACCESS_LOAD); // R18
               next_seq = IHP_RESETTING; // R18
            end
            default: begin
            end
         endcase
      end
      if (seq == IHP_ACCESS) begin
         // Internal access completes at its cycle-count deadline.
         if (timer != 10'h000) begin
            next_timer = timer - 10'h001;
         end else begin
            if (ctl[CTL_TARGET_HI_POS] && ctl[CTL_TARGET_LO_POS]) begin // R6
               if (ctl[CTL_OP_LO_POS]) begin // R7
                  next_dat = (idx == IDX_DEVICE_SETUP) ? dev : fsh; // R8 R16
                  next_ctl = ctl | 8'h03; // R20
               end else if (idx == IDX_DEVICE_SETUP) begin // R8
                  next_dev = dat;
               end else if (idx == IDX_FRAME_SHIFT_SETUP) begin // R8
                  next_fsh = dat;
               end
            end else if (ctl[CTL_TARGET_HI_POS] ^ ctl[CTL_TARGET_LO_POS]) begin // R6
               store_we = 1'b1; // R9
            end else begin
               // Store read leaves bits 9:8 in the control byte.
               next_dat = store[idx][7:0]; // R16
               next_ctl = (ctl & CTL_KEEP_MASK) | {6'h00, store[idx][9:8]}; // R16 R17
            end
            next_pending = 1'b0; // R11
            next_seq = IHP_IDLE;
         end
      end
      if (seq == IHP_RESETTING) begin
         if (timer != 10'h000) begin
            next_timer = timer - 10'h001;
         end else begin
            next_pending = 1'b0; // R18
            next_seq = IHP_IDLE;
         end
      end
      // Abort wins over the state, pending bit, timer and store write; byte and register loads still go through.
      if (ops[OPS_ABORT_POS]) begin // R14
         next_seq = IHP_IDLE; // R22
         next_pending = 1'b0; // R22
         next_timer = 10'h000;
         store_we = 1'b0;
      end
   end

   // Sequencer and register file storage.
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         seq <= IHP_IDLE;
         ctl <= WINDOW_RESET;
         dat <= WINDOW_RESET;
         idx <= WINDOW_RESET;
         ops <= OPS_RESET;
         dev <= DEVICE_SETUP_RESET;
         fsh <= FRAME_SHIFT_RESET;
         pending <= 1'b0;
         timer <= 10'h000;
      end else begin
         seq <= next_seq;
         ctl <= next_ctl;
         dat <= next_dat;
         idx <= next_idx;
         ops <= next_ops;
         dev <= next_dev;
         fsh <= next_fsh;
         pending <= next_pending;
         timer <= next_timer;
      end
   end

   // Connection store is a plain array with no reset so it can map to RAM.
   always_ff @(posedge CLOCK_I) begin
      if (store_we) begin
         store[idx] <= {ctl[CTL_OP_HI_POS], ctl[CTL_OP_LO_POS], dat}; // R9 R19
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read data: selected byte is presented while the read strobe is low.
   assign busy_flags = {pending, MEMORY_CLEAR_BUSY_I, 6'h00};

   // The byte is captured on the first cycle of the read and then held, so a flag
   // that moves in mid-read cannot change what the host latches.
   always_comb begin
      next_rd_data = bus_o;
      next_bus_oe = rd_active;
      if (rd_active && !bus_oe) begin
         if (sel_s == REG_SEL_DIRECT) begin
            next_rd_data = busy_flags; // R2 R3 R13
         end else begin
            case (seq)
               IHP_RD_ONE: next_rd_data = dat; // R17
               IHP_RD_TWO: next_rd_data = idx; // R17
               default: next_rd_data = ctl_view(ctl); // R17 R21
            endcase
         end
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         bus_o <= 8'h00;
         bus_oe <= 1'b0;
      end else begin
         bus_o <= next_rd_data;
         bus_oe <= next_bus_oe;
      end
   end

   assign rd_data = bus_o;
   assign HOST_DATA_BUS_O = rd_data;
   assign HOST_DATA_BUS_OE_O = bus_oe;
   assign OPERATING_SETUP_O = ops;
   assign DEVICE_SETUP_O = dev;
   assign FRAME_SHIFT_SETUP_O = fsh;
endmodule : ihp_host_port

// >>> hdl/ihp_pkg.sv
package ihp_pkg;
   // Direct addresses on the single register-select line.
   localparam logic REG_SEL_DIRECT = 1'b0;
   localparam logic REG_SEL_WINDOW = 1'b1;
   // Indirect register indexes.
   localparam logic [7:0] IDX_DEVICE_SETUP = 8'hfe;
   localparam logic [7:0] IDX_FRAME_SHIFT_SETUP = 8'hff;
   // Control byte field positions.
   localparam int CTL_TARGET_HI_POS = 5;
   localparam int CTL_TARGET_LO_POS = 4;
   localparam int CTL_OP_HI_POS = 1;
   localparam int CTL_OP_LO_POS = 0;
   // Unused control bits read back as one.
   localparam logic [7:0] CTL_UNUSED_MASK = 8'hcc;
   localparam logic [7:0] CTL_KEEP_MASK = 8'h30;
   // Operating setup field positions.
   localparam int OPS_ABORT_POS = 6;
   // Condition flag positions.
   localparam int FLG_PENDING_POS = 7;
   localparam int FLG_CLEAR_BUSY_POS = 6;
   // Reset values.
   localparam logic [7:0] OPS_RESET = 8'h00;
   localparam logic [7:0] DEVICE_SETUP_RESET = 8'hff;
   localparam logic [7:0] FRAME_SHIFT_RESET = 8'h00;
   localparam logic [7:0] WINDOW_RESET = 8'h00;
   // Store shape.
   localparam int STORE_DEPTH = 256;
   localparam int STORE_WIDTH = 10;
   // Internal access time and its cycle count at 125 MHz.
   localparam int CLOCK_PERIOD_PS = 8000;
   localparam int ACCESS_TIME_NS = 900;
   localparam int ACCESS_CYCLES = (ACCESS_TIME_NS * 1000) / CLOCK_PERIOD_PS;
   // Pin to sequencer latency of a strobe edge, spent out of the access budget.
   localparam int STROBE_LATENCY_CYCLES = 5;
   localparam int ACCESS_LOAD = ACCESS_CYCLES - STROBE_LATENCY_CYCLES - 1;
   // Sequencer states.
   typedef enum logic [2:0] {
      IHP_IDLE,
      IHP_GOT_CTL,
      IHP_GOT_DATA,
      IHP_ACCESS,
      IHP_RD_ONE,
      IHP_RD_TWO,
      IHP_RESETTING
   } ihp_seq_t;
endpackage : ihp_pkg

// >>> hdl/ihp_sync.sv
`timescale 1ns/100ps
module ihp_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clock_i,                   // Device clock.
   input wire logic rst_b_i,                   // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] async_i,       // Asynchronous pin levels.
   output logic [WIDTH-1:0] level_o            // Filtered level.
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] level;
   logic [WIDTH-1:0] next_level;

   // Refuse an empty synchroniser at elaboration.
   if (WIDTH < 1) begin : g_bad_width
      $error("ihp_sync width must be positive.");
   end

   //////////////////////////////////////////////////////////////////////////
   // A level is accepted only when the second and third stage agree.
   always_comb begin
      next_level = level;
      for (int i = 0; i < WIDTH; i++) begin
         if (stage2[i] == stage3[i]) begin
            next_level[i] = stage2[i];
         end
      end
   end

   // Resets to all ones, the idle state of active-low strobes.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage1 <= '1;
         stage2 <= '1;
         stage3 <= '1;
         level <= '1;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
         level <= next_level;
      end
   end

   assign level_o = level;
endmodule : ihp_sync

// >>> sim/ihp_host_port_monitor.sv
`timescale 1ns/100ps
module ihp_host_port_monitor (
   input wire logic CLOCK_I,               // Clock.
   input wire logic RST_B_I,               // Reset.
   input wire logic CHIP_SELECT_B_I,       // Select.
   input wire logic WRITE_STROBE_B_I,      // Write.
   input wire logic READ_STROBE_B_I,       // Read.
   input wire logic REGISTER_SELECT_I,     // Address.
   input wire logic [7:0] HOST_DATA_BUS_I, // Data in.
   input wire logic [7:0] HOST_DATA_BUS_O, // Data out.
   input wire logic HOST_DATA_BUS_OE_O,    // Drive.
   input wire logic [7:0] OPERATING_SETUP_O,  // Setup.
   input wire logic [7:0] DEVICE_SETUP_O,     // Device setup.
   input wire logic [7:0] FRAME_SHIFT_SETUP_O // Frame shift.
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!RST_B_I);
   ////////////////////////
   // Cycles since the write strobe was last low; reads do not restart it, because
   // the host may poll the flags while the internal access runs.
   logic [7:0] idle_cnt;
   logic [7:0] next_idle_cnt;
   always_comb begin
      next_idle_cnt = 8'h00;
      if (WRITE_STROBE_B_I) begin
         next_idle_cnt = (idle_cnt == 8'hff) ? idle_cnt : idle_cnt + 8'h01;
      end
   end
   // Counter register.
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         idle_cnt <= 8'h00;
      end else begin
         idle_cnt <= next_idle_cnt;
      end
   end
   ////////////////////////
   // Direct write pulse, then the idle tail in which it is taken.
   sequence wr_direct;
      (!CHIP_SELECT_B_I && !REGISTER_SELECT_I && !WRITE_STROBE_B_I)[*4] ##1
         (!CHIP_SELECT_B_I && !REGISTER_SELECT_I && WRITE_STROBE_B_I)[*6];
   endsequence
   sequence rd_held;
      !READ_STROBE_B_I[*6];
   endsequence
   chk_reset_values: assert property (
      $rose(RST_B_I) |-> OPERATING_SETUP_O == 8'h00 && DEVICE_SETUP_O == 8'hff
         && FRAME_SHIFT_SETUP_O == 8'h00 && !HOST_DATA_BUS_OE_O)
      else $error("reset contents wrong");
   chk_ops_load: assert property (
      wr_direct |-> OPERATING_SETUP_O == $past(HOST_DATA_BUS_I, 8))
      else $error("setup write not loaded");
   chk_oe_cause: assert property (
      $rose(HOST_DATA_BUS_OE_O) |-> !$past(READ_STROBE_B_I, 3) && !$past(CHIP_SELECT_B_I, 3))
      else $error("bus driven without read");
   chk_oe_release: assert property (
      READ_STROBE_B_I[*8] |-> !HOST_DATA_BUS_OE_O)
      else $error("bus still driven");
   chk_cs_idle: assert property (
      CHIP_SELECT_B_I[*8] |-> !HOST_DATA_BUS_OE_O && $stable(OPERATING_SETUP_O))
      else $error("active while deselected");
   chk_write_no_oe: assert property (
      !WRITE_STROBE_B_I[*6] |-> !HOST_DATA_BUS_OE_O)
      else $error("bus driven in write");
   chk_regs_hold: assert property (
      ($changed(DEVICE_SETUP_O) || $changed(FRAME_SHIFT_SETUP_O))
         |-> idle_cnt > 8'h04 && idle_cnt < 8'h71)
      else $error("indirect register changed outside its access time");
   chk_data_stands: assert property (
      rd_held ##0 (HOST_DATA_BUS_OE_O && $past(HOST_DATA_BUS_OE_O)) |-> $stable(HOST_DATA_BUS_O))
      else $error("read data moved");
endmodule : ihp_host_port_monitor
bind ihp_host_port ihp_host_port_monitor i_mon (.CLOCK_I, .RST_B_I, .CHIP_SELECT_B_I,
   .WRITE_STROBE_B_I, .READ_STROBE_B_I, .REGISTER_SELECT_I, .HOST_DATA_BUS_I,
   .HOST_DATA_BUS_O, .HOST_DATA_BUS_OE_O, .OPERATING_SETUP_O, .DEVICE_SETUP_O,
   .FRAME_SHIFT_SETUP_O);

// >>> sim/ihp_host_model.sv
`timescale 1ns/100ps
module ihp_host_model (
   input wire logic clk_i,          // Clock.
   input wire logic [7:0] rdata_i,  // Device data.
   output logic cs_b_o,             // Select.
   output logic wr_b_o,             // Write.
   output logic rd_b_o,             // Read.
   output logic sel_o,              // Address.
   output logic [7:0] wdata_o,      // Host data.
   output logic got_o,              // Read taken.
   output logic [7:0] got_val_o     // Byte read.
);
   // Idle levels at time zero.
   initial begin
      cs_b_o = 1'b1;
      wr_b_o = 1'b1;
      rd_b_o = 1'b1;
      sel_o = 1'b0;
      wdata_o = 8'h5a;
      got_o = 1'b0;
      got_val_o = 8'h00;
   end
   // One strobe pulse; the released bus shows the inverse, never a stale copy.
   task automatic xfer(input logic s, input logic wr, input logic [7:0] v);
      @(posedge clk_i);
      cs_b_o <= 1'b0;
      sel_o <= s;
      wdata_o <= v;
      wr_b_o <= !wr;
      rd_b_o <= wr;
      repeat (7) @(posedge clk_i);
      got_val_o <= rdata_i;
      got_o <= !wr;
      wr_b_o <= 1'b1;
      rd_b_o <= 1'b1;
      @(posedge clk_i);
      got_o <= 1'b0;
      repeat (7) @(posedge clk_i);
      cs_b_o <= 1'b1;
      wdata_o <= ~v;
   endtask : xfer
   // A write pulse with the chip left deselected, which the device must ignore.
   task automatic ghost(input logic [7:0] v);
      @(posedge clk_i);
      sel_o <= 1'b0;
      wdata_o <= v;
      wr_b_o <= 1'b0;
      repeat (7) @(posedge clk_i);
      wr_b_o <= 1'b1;
      repeat (8) @(posedge clk_i);
   endtask : ghost
endmodule : ihp_host_model

// >>> sim/tb_indirect_register_host_port.sv
`timescale 1ns/100ps
module tb_indirect_register_host_port;
   import ihp_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic clr_busy = 1'b0;
   logic cs_b, wr_b, rd_b, sel, got, oe;
   logic [7:0] wdata, rdata, bus, got_val, ops, dev, fsh, v;
   logic [9:0] cm_word [4];
   logic [7:0] cm_addr [4];
   logic [7:0] exp_q [$];
   int error_cnt = 0;
   int num_checks = 0;
   integer seed = 84;
   // The bus carries the device's byte only while it drives.
   assign bus = oe ? rdata : wdata;
   always #4 clk = ~clk;
   ihp_host_port i_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .CHIP_SELECT_B_I(cs_b),
      .WRITE_STROBE_B_I(wr_b), .READ_STROBE_B_I(rd_b), .REGISTER_SELECT_I(sel),
      .HOST_DATA_BUS_I(bus), .MEMORY_CLEAR_BUSY_I(clr_busy), .HOST_DATA_BUS_O(rdata),
      .HOST_DATA_BUS_OE_O(oe), .OPERATING_SETUP_O(ops), .DEVICE_SETUP_O(dev),
      .FRAME_SHIFT_SETUP_O(fsh));
   ihp_host_model i_host (.clk_i(clk), .rdata_i(rdata), .cs_b_o(cs_b), .wr_b_o(wr_b),
      .rd_b_o(rd_b), .sel_o(sel), .wdata_o(wdata), .got_o(got), .got_val_o(got_val));
   ////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      num_checks++;
      if (seen !== want) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict
   // Note the byte a read should return, then read it.
   task automatic rdb(input logic s, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.xfer(s, 1'b0, 8'h00);
   endtask : rdb
   // The flags are captured about 900 ns after the last strobe rose, so an
   // access that overruns its budget shows up as a stale pending bit.
   task automatic settle;
      repeat (99) @(posedge clk);
      rdb(REG_SEL_DIRECT, 8'h00);
   endtask : settle
   task automatic ind(input logic [7:0] c, input logic [7:0] d, input logic [7:0] a);
      i_host.xfer(REG_SEL_WINDOW, 1'b1, c);
      rdb(REG_SEL_DIRECT, 8'h80);
      i_host.xfer(REG_SEL_WINDOW, 1'b1, d);
      i_host.xfer(REG_SEL_WINDOW, 1'b1, a);
      settle;
   endtask : ind
   task automatic rdout(input logic [7:0] c, input logic [7:0] d, input logic [7:0] a);
      rdb(REG_SEL_WINDOW, c);
      rdb(REG_SEL_DIRECT, 8'h80);
      rdb(REG_SEL_WINDOW, d);
      rdb(REG_SEL_WINDOW, a);
      settle;
   endtask : rdout
   ////////////////////////
   // Each byte read is matched against the oldest note.
   always @(posedge clk) begin
      if (got === 1'b1) begin
         check(got_val, exp_q.pop_front());
      end
   end
   // Whole run is a few thousand cycles; this limit is generous.
   initial begin
      #100000;
      error_cnt++;
      give_verdict;
   end
   // Main sequence.
   initial begin
      repeat (3) @(posedge clk);
      check(ops, OPS_RESET);
      check(dev, DEVICE_SETUP_RESET);
      check(fsh, FRAME_SHIFT_RESET);
      rst_b <= 1'b1;
      v = 8'($random(seed)) & 8'hbf;
      i_host.xfer(REG_SEL_DIRECT, 1'b1, v);
      check(ops, v);
      i_host.ghost(~v);
      check(ops, v);
      clr_busy <= 1'b1;
      rdb(REG_SEL_DIRECT, 8'h40);
      clr_busy <= 1'b0;
      ind(8'h30, 8'h55, IDX_FRAME_SHIFT_SETUP);
      check(fsh, 8'h55);
      ind(8'h31, 8'h00, IDX_FRAME_SHIFT_SETUP);
      rdout(8'hff, 8'h55, IDX_FRAME_SHIFT_SETUP);
      v = 8'($random(seed));
      ind(8'h32, v, IDX_DEVICE_SETUP);
      check(dev, v);
      ind(8'h31, 8'h00, IDX_DEVICE_SETUP);
      rdout(8'hff, v, IDX_DEVICE_SETUP);
      for (int i = 0; i < 4; i++) begin
         cm_word[i] = 10'($random(seed));
         cm_addr[i] = {i[1:0], 6'($random(seed))};
         ind({2'b00, i[0] ? 2'b01 : 2'b10, 2'b00, cm_word[i][9:8]}, cm_word[i][7:0],
            cm_addr[i]);
      end
      for (int i = 0; i < 4; i++) begin
         ind(8'h00, 8'h00, cm_addr[i]);
         rdout({6'h33, cm_word[i][9:8]}, cm_word[i][7:0], cm_addr[i]);
      end
      i_host.xfer(REG_SEL_WINDOW, 1'b1, 8'h30);
      i_host.xfer(REG_SEL_DIRECT, 1'b1, 8'h40);
      rdb(REG_SEL_DIRECT, 8'h00);
      i_host.xfer(REG_SEL_DIRECT, 1'b1, 8'h00);
      ind(8'h30, 8'ha5, IDX_FRAME_SHIFT_SETUP);
      check(fsh, 8'ha5);
      give_verdict;
   end
endmodule : tb_indirect_register_host_port
